/* tb_usart_master_spi_mode.sv */
`timescale 1ns/10ps
module tb_usart_master_spi_mode;
  logic        clk_i, rst_n_i, ce_i, transmitter_enable_i, receiver_enable_i;
  logic [1:0]  mode_select_field_i;
  logic        clock_polarity_bit_i, clock_phase_bit_i, bit_order_select_i;
  logic [11:0] baud_divider_i;
  logic        data_wr_i, data_rd_i, tx_complete_clr_i, serial_in_pin_i;
  logic [7:0]  data_wr_byte_i, data_rd_byte_o, w, r;
  logic        tx_buffer_empty_flag_o, rx_complete_flag_o, tx_complete_flag_o;
  logic        frame_error_flag_o, overrun_flag_o, parity_error_flag_o;
  logic        transfer_clock_pin_o, transfer_clock_oe_o, serial_out_pin_o;
  logic        serial_out_oe_o, serial_in_used_o, active_o, rxe;
  logic [7:0]  rxm[$], txm[$];
  int          fail_count, num_checks;

  ums_mspi u_ums_mspi (.*);
  ums_slv u_ums_slv (.sck_i(transfer_clock_pin_o), .mosi_i(serial_out_pin_o),
    .cpol_i(clock_polarity_bit_i), .cpha_i(clock_phase_bit_i),
    .lsb_i(bit_order_select_i), .miso_o(serial_in_pin_i));

  // ********
  // Helpers
  // ********
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic flag(input int k);
    return k == 0 ? tx_buffer_empty_flag_o : k == 1 ? rx_complete_flag_o : tx_complete_flag_o;
  endfunction

  // Bounded wait on a flag; a hang ends the run as a failure
  task automatic wt(input int k);
    int n;
    n = 0;
    while (flag(k) !== 1'b1) begin
      if (n++ == 3000) begin
        fail_count++;
        conclude();
      end
      @(posedge clk_i);
      #1;
    end
  endtask

  // Enable first, divider one edge later so the clock starts at once
  task automatic cfg(input logic [1:0] m, input logic t, input logic x, input logic [2:0] pho);
    @(posedge clk_i);
    mode_select_field_i <= m;
    transmitter_enable_i <= t;
    receiver_enable_i <= x;
    {clock_polarity_bit_i, clock_phase_bit_i, bit_order_select_i} <= pho;
    rxe = x;
    @(posedge clk_i);
    baud_divider_i <= 12'(2 + $urandom_range(3));
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] d);
    wt(0);
    @(posedge clk_i);
    data_wr_i <= 1'b1;
    data_wr_byte_i <= d;
    @(posedge clk_i);
    data_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] e);
    wt(1);
    chk("rx byte", data_rd_byte_o, e);
    @(posedge clk_i);
    data_rd_i <= 1'b1;
    @(posedge clk_i);
    data_rd_i <= 1'b0;
    #1;
  endtask

  // Model keeps two received bytes and drops any later arrival
  task automatic xfer();
    w = 8'($urandom);
    r = 8'($urandom);
    u_ums_slv.put(r);
    txm.push_back(w);
    if (rxe && rxm.size() < 2) rxm.push_back(r);
    wr(w);
  endtask

  task automatic fin();
    wt(2);
    chk("idle clock", transfer_clock_pin_o, clock_polarity_bit_i);
    while (txm.size() > 0) chk("mosi byte", u_ums_slv.got_q.pop_front(), txm.pop_front());
    @(posedge clk_i);
    tx_complete_clr_i <= 1'b1;
    @(posedge clk_i);
    tx_complete_clr_i <= 1'b0;
    #1;
    chk("tx complete clear", tx_complete_flag_o, 1'b0);
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(32'h2BEB));
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    {transmitter_enable_i, receiver_enable_i, mode_select_field_i} = 4'h0;
    {clock_polarity_bit_i, clock_phase_bit_i, bit_order_select_i} = 3'h0;
    {data_wr_i, data_rd_i, tx_complete_clr_i} = 3'h0;
    baud_divider_i = 12'h000;
    data_wr_byte_i = 8'h00;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("reset pins", {tx_buffer_empty_flag_o, rx_complete_flag_o, tx_complete_flag_o,
      frame_error_flag_o, overrun_flag_o, parity_error_flag_o,
      transfer_clock_pin_o, serial_out_pin_o}, 8'h81);
    // Every polarity, phase and order, one byte each way
    for (int i = 0; i < 8; i++) begin
      cfg(2'h3, 1'b1, 1'b1, 3'(i));
      chk("enables", {active_o, transfer_clock_oe_o, serial_out_oe_o, serial_in_used_o}, 8'h0F);
      xfer();
      // Clock enable low must hold the pending frame where it stands
      if (i == 5) begin
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        #1;
        chk("ce freeze", {tx_complete_flag_o, u_ums_slv.n != 0,
          transfer_clock_pin_o != clock_polarity_bit_i}, 8'h00);
        @(posedge clk_i);
        ce_i <= 1'b1;
      end
      rd(rxm.pop_front());
      fin();
    end
    // Four back to back writes, no reads: the last two arrivals are dropped
    cfg(2'h3, 1'b1, 1'b1, 3'h1);
    repeat (4) xfer();
    fin();
    rd(rxm.pop_front());
    rd(rxm.pop_front());
    chk("rx overflow", rx_complete_flag_o, 1'b0);
    // Receiver off still clocks a frame but stores nothing
    cfg(2'h3, 1'b1, 1'b0, 3'h4);
    xfer();
    fin();
    chk("rx off", {rx_complete_flag_o, serial_in_used_o}, 8'h00);
    // Wrong mode field: no drive and a write starts nothing
    cfg(2'h2, 1'b1, 1'b1, 3'h4);
    chk("mode off", {active_o, transfer_clock_oe_o, serial_out_oe_o}, 8'h00);
    wr(8'h5A);
    repeat (100) @(posedge clk_i);
    #1;
    chk("no frame", {tx_complete_flag_o, u_ums_slv.got_q.size() != 0}, 8'h00);
    cfg(2'h3, 1'b0, 1'b1, 3'h4);
    chk("tx off", active_o, 1'b0);
    conclude();
  end
endmodule

/* ums_mspi.sv */
`timescale 1ns/10ps
// Behaviour
// - Transmitter enable required; then serial out pin carries shifted data.
// - Receiver optional; when enabled the serial in pin feeds the shifter.
// - Transfer clock pin driven whether transmitter alone or both enabled.
// - Every transfer starts only on a software data write.
// - Buffered byte enters shift register once it is free for a frame.
// - Receive buffer full: newest byte dropped, older bytes kept.
// - Frame error, overrun and parity flags always read zero.
// - Receive-complete, transmit-complete, buffer-empty flags act as usual.
// - Transmit path is holding buffer plus shift register.
// - Receive path has a two-entry buffer past the shifter.
// - No write collision or double rate bit; speed from divider only.
// - Master only, no slave-select output.
// - Frames are exactly eight bits; idle data line rests high.
// - Polarity and phase pick one of four modes, opposite edges.
// - Bit order one sends LSB first, zero MSB first, both directions.
// - Master SPI active only when both mode select bits are one.
module ums_mspi
  import ums_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        transmitter_enable_i,
  input  wire logic        receiver_enable_i,
  input  wire logic [1:0]  mode_select_field_i,
  input  wire logic        clock_polarity_bit_i,
  input  wire logic        clock_phase_bit_i,
  input  wire logic        bit_order_select_i,
  input  wire logic [11:0] baud_divider_i,
  input  wire logic        data_wr_i,
  input  wire logic [7:0]  data_wr_byte_i,
  input  wire logic        data_rd_i,
  output logic      [7:0]  data_rd_byte_o,
  input  wire logic        tx_complete_clr_i,
  output logic             tx_buffer_empty_flag_o,
  output logic             rx_complete_flag_o,
  output logic             tx_complete_flag_o,
  output logic             frame_error_flag_o,
  output logic             overrun_flag_o,
  output logic             parity_error_flag_o,
  output logic             transfer_clock_pin_o,
  output logic             transfer_clock_oe_o,
  output logic             serial_out_pin_o,
  output logic             serial_out_oe_o,
  input  wire logic        serial_in_pin_i,
  output logic             serial_in_used_o,
  output logic             active_o
);

  // ****************************************************************
  // Mode decode and pin ownership
  // ****************************************************************
  logic       mspi_on;
  logic       tx_on_ff;
  logic       rx_on;
  logic       miso_s;
  ums_state_t state_ff;
  logic       hold_full_ff;
  logic [7:0] hold_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] rx_sh_ff;
  logic [3:0] edge_ff;
  logic [11:0] div_ff;
  logic       tick;
  logic       sck_ff;
  logic       mosi_ff;
  logic       frame_done;
  logic       rx_push;
  logic       rx_ready;
  logic       rx_valid;
  logic       tx_cmpl_ff;
  logic       sample_edge;
  logic       wr_take;

  assign mspi_on = (mode_select_field_i == UMS_MODE_MSPI);
  assign rx_on   = mspi_on && receiver_enable_i;
  assign active_o = mspi_on && tx_on_ff;

  // Transmitter stays on until pending data has gone out
  // A write taken in the same cycle keeps it on, or that byte would be stranded
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_on_ff <= 1'b0;
    end else if (ce_i) begin
      if (transmitter_enable_i && mspi_on) begin
        tx_on_ff <= 1'b1;
      end else if (state_ff == UMS_IDLE && !hold_full_ff && !wr_take) begin
        tx_on_ff <= 1'b0;
      end
    end
  end

  // Pin overrides; no slave select exists at all
  assign serial_out_oe_o     = active_o;
  assign transfer_clock_oe_o = active_o;
  assign serial_in_used_o    = rx_on;
  assign transfer_clock_pin_o = sck_ff;
  assign serial_out_pin_o     = mosi_ff;

  // ****************************************************************
  // Unused status
  // ****************************************************************
  // Error flags unused in this mode; no collision or double rate bits
  assign frame_error_flag_o  = 1'b0;
  assign overrun_flag_o      = 1'b0;
  assign parity_error_flag_o = 1'b0;

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // Input pin is asynchronous to clk_i
  ums_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .d_i     (serial_in_pin_i),
    .q_o     (miso_s)
  );

  // ****************************************************************
  // Baud divider: one tick per half bit, fosc / (2 (div + 1))
  // ****************************************************************
  assign tick = (div_ff == UMS_BAUD_RST);

  // Reloads between frames and on every tick; a new rate applies next half bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= UMS_BAUD_RST;
    end else if (ce_i) begin
      if (state_ff != UMS_SHIFT || tick) begin
        div_ff <= baud_divider_i;
      end else begin
        div_ff <= div_ff - 12'h001;
      end
    end
  end

  // ****************************************************************
  // Transmit holding buffer
  // ****************************************************************
  // Write taken only while the holding buffer is free and the link owns its pins
  assign wr_take = data_wr_i && !hold_full_ff && active_o;

  // Write lands in holding buffer; a write while full is ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_full_ff <= 1'b0;
      hold_ff      <= UMS_BYTE_RST;
    end else if (ce_i) begin
      if (state_ff == UMS_LOAD) begin
        hold_full_ff <= 1'b0;
      end else if (wr_take) begin
        hold_full_ff <= 1'b1;
        hold_ff      <= data_wr_byte_i;
      end
    end
  end

  assign tx_buffer_empty_flag_o = !hold_full_ff;

  // ****************************************************************
  // Shift engine
  // ****************************************************************
  // Sampling edge: leading when phase is zero, trailing otherwise
  assign sample_edge = tick && (edge_ff[0] == clock_phase_bit_i);
  assign frame_done  = (state_ff == UMS_SHIFT) && tick && (edge_ff == UMS_EDGES_FRAME);

  // Frame sequencing; a queued byte follows back to back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= UMS_IDLE;
      edge_ff  <= UMS_EDGE_RST;
    end else if (ce_i) begin
      case (state_ff)
        UMS_IDLE: begin
          if (hold_full_ff) begin
            state_ff <= UMS_LOAD;
          end
        end
        // One cycle here lets the shifter take the byte before the first tick
        UMS_LOAD: begin
          state_ff <= UMS_SHIFT;
          edge_ff  <= UMS_EDGE_RST;
        end
        UMS_SHIFT: begin
          if (frame_done) begin
            state_ff <= hold_full_ff ? UMS_LOAD : UMS_IDLE;
          end else if (tick) begin
            edge_ff <= edge_ff + 4'h1;
          end
        end
        default: begin
          state_ff <= UMS_IDLE;
        end
      endcase
    end
  end

  // Clock pin: rests at polarity, toggles each half bit
  // A polarity change while idle moves the pin, so set it before any frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_ff <= 1'b0;
    end else if (ce_i) begin
      if (state_ff == UMS_SHIFT && tick) begin
        sck_ff <= ~sck_ff;
      end else if (state_ff != UMS_SHIFT) begin
        sck_ff <= clock_polarity_bit_i;
      end
    end
  end

  // Transmit shifter; phase zero presents the first bit before clocking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sh_ff <= UMS_BYTE_RST;
      mosi_ff  <= 1'b1;
    end else if (ce_i) begin
      if (state_ff == UMS_LOAD) begin
        tx_sh_ff <= hold_ff;
        if (!clock_phase_bit_i) begin
          mosi_ff  <= bit_order_select_i ? hold_ff[0] : hold_ff[7];
          tx_sh_ff <= bit_order_select_i ? {1'b0, hold_ff[7:1]}
                                         : {hold_ff[6:0], 1'b0};
        end
      end else if (state_ff == UMS_SHIFT && tick && !sample_edge
                   && !(clock_phase_bit_i == 1'b0 && edge_ff == UMS_EDGES_FRAME)) begin
        mosi_ff  <= bit_order_select_i ? tx_sh_ff[0] : tx_sh_ff[7];
        tx_sh_ff <= bit_order_select_i ? {1'b0, tx_sh_ff[7:1]}
                                       : {tx_sh_ff[6:0], 1'b0};
      end else if (state_ff == UMS_IDLE) begin
        mosi_ff <= 1'b1;
      end
    end
  end

  // Receive shifter, same bit order as transmit
  // The pin reaches here two cycles late through the synchroniser, so a
  // divider below two would sample the previous bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sh_ff <= UMS_BYTE_RST;
    end else if (ce_i) begin
      if (state_ff == UMS_SHIFT && sample_edge) begin
        rx_sh_ff <= bit_order_select_i ? {miso_s, rx_sh_ff[7:1]}
                                       : {rx_sh_ff[6:0], miso_s};
      end
    end
  end

  // ****************************************************************
  // Receive buffer and completion flags
  // ****************************************************************
  // With phase one the last sample lands on the final edge, so push one cycle later
  logic rx_push_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_push_ff <= 1'b0;
    end else if (ce_i) begin
      rx_push_ff <= frame_done && rx_on;
    end
  end
  assign rx_push = rx_push_ff;

  // Full buffer refuses the push, dropping the newest byte
  ums_rxbuf u_rxbuf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .flush_i     (!rx_on),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_ready),
    .in_data_i   (rx_sh_ff),
    .out_valid_o (rx_valid),
    .out_ready_i (data_rd_i),
    .out_data_o  (data_rd_byte_o)
  );

  assign rx_complete_flag_o = rx_valid;

  // Transmit complete: frame out and nothing queued; set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cmpl_ff <= 1'b0;
    end else if (ce_i) begin
      // A byte written on the last tick counts as pending, so no early complete
      if (frame_done && !hold_full_ff && !wr_take) begin
        tx_cmpl_ff <= 1'b1;
      end else if (tx_complete_clr_i) begin
        tx_cmpl_ff <= 1'b0;
      end
    end
  end

  assign tx_complete_flag_o = tx_cmpl_ff;

endmodule

/* ums_mspi_chk.sv */
`timescale 1ns/10ps
module ums_mspi_chk
  import ums_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       ce_i,
  input wire logic       receiver_enable_i,
  input wire logic [1:0] mode_select_field_i,
  input wire logic       data_wr_i,
  input wire logic       data_rd_i,
  input wire logic [7:0] data_rd_byte_o,
  input wire logic       tx_buffer_empty_flag_o,
  input wire logic       rx_complete_flag_o,
  input wire logic       tx_complete_flag_o,
  input wire logic       frame_error_flag_o,
  input wire logic       overrun_flag_o,
  input wire logic       parity_error_flag_o,
  input wire logic       transfer_clock_pin_o,
  input wire logic       transfer_clock_oe_o,
  input wire logic       serial_out_oe_o,
  input wire logic       serial_in_used_o,
  input wire logic       active_o
);
  // ********
  // Port relations
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Write accepted, then holding buffer reported full
  sequence wr_take;
    data_wr_i && ce_i && active_o && tx_buffer_empty_flag_o;
  endsequence
  sequence buf_full;
    !tx_buffer_empty_flag_o;
  endsequence

  err_zero_a: assert property (!(frame_error_flag_o | overrun_flag_o | parity_error_flag_o))
    else $error("status error flag set");
  clk_oe_a: assert property (transfer_clock_oe_o == active_o)
    else $error("clock enable differs from active");
  out_oe_a: assert property (serial_out_oe_o == active_o)
    else $error("data enable differs from active");
  in_used_a: assert property (serial_in_used_o == (receiver_enable_i && mode_select_field_i == UMS_MODE_MSPI))
    else $error("input pin use wrong");
  mode_gate_a: assert property ((mode_select_field_i != UMS_MODE_MSPI)[*2] |-> !active_o)
    else $error("active outside master mode");
  wr_hold_a: assert property (wr_take |=> buf_full)
    else $error("holding buffer not taken");
  txc_empty_a: assert property ($rose(tx_complete_flag_o) |-> tx_buffer_empty_flag_o)
    else $error("complete with byte pending");
  rx_flush_a: assert property (!receiver_enable_i [*2] |-> !rx_complete_flag_o)
    else $error("receive buffer not flushed");
  rx_keep_a: assert property (rx_complete_flag_o && !data_rd_i && receiver_enable_i |=> rx_complete_flag_o && $stable(data_rd_byte_o))
    else $error("buffered byte lost");
  sck_still_a: assert property (!active_o [*2] |-> $stable(transfer_clock_pin_o))
    else $error("clock moved while inactive");
endmodule

bind ums_mspi ums_mspi_chk u_ums_mspi_chk (.*);

/* ums_pkg.sv */
package ums_pkg;

  // ****************************************************************
  // Frame and divider constants
  // ****************************************************************
  localparam int unsigned UMS_FRAME_BITS  = 8;
  localparam int unsigned UMS_BAUD_W      = 12;
  localparam int unsigned UMS_CNT_W       = 4;
  localparam logic [1:0]  UMS_MODE_MSPI   = 2'h3;
  localparam logic [11:0] UMS_BAUD_RST    = 12'h000;
  localparam logic [7:0]  UMS_BYTE_RST    = 8'h00;
  localparam logic [3:0]  UMS_EDGES_FRAME = 4'hF;
  localparam logic [3:0]  UMS_EDGE_RST    = 4'h0;

  // Shift engine states
  typedef enum logic [1:0] {
    UMS_IDLE,
    UMS_LOAD,
    UMS_SHIFT
  } ums_state_t;

endpackage

/* ums_rxbuf.sv */
`timescale 1ns/10ps
module ums_rxbuf
  import ums_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       flush_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  input  wire logic [7:0] in_data_i,
  output logic            out_valid_o,
  input  wire logic       out_ready_i,
  output logic      [7:0] out_data_o
);

  // ****************************************************************
  // Two-entry buffer
  // ****************************************************************
  logic [7:0] mem_ff [2];
  logic       wr_ptr_ff;
  logic       rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic       push;
  logic       pop;

  assign in_ready_o  = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage array; a full buffer refuses, so the newest byte drops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ff[0] <= UMS_BYTE_RST;
      mem_ff[1] <= UMS_BYTE_RST;
    end else if (ce_i && push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and occupancy; flush empties it at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
    end else if (ce_i) begin
      if (flush_i) begin
        wr_ptr_ff <= 1'b0;
        rd_ptr_ff <= 1'b0;
        cnt_ff    <= 2'h0;
      end else begin
        if (push) begin
          wr_ptr_ff <= ~wr_ptr_ff;
        end
        if (pop) begin
          rd_ptr_ff <= ~rd_ptr_ff;
        end
        cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  // Data output from registers
  assign out_data_o = mem_ff[rd_ptr_ff];

endmodule

/* ums_slv.sv */
`timescale 1ns/10ps
module ums_slv (
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic cpol_i,
  input  wire logic cpha_i,
  input  wire logic lsb_i,
  output logic      miso_o
);
  logic [7:0] tx_q[$];
  logic [7:0] got_q[$];
  logic [7:0] sh;
  int         n = 0;
  int         qn = 0;
  int         b;

  // Queue a reply byte; the bump wakes the output process
  task automatic put(input logic [7:0] d);
    tx_q.push_back(d);
    qn++;
  endtask

  // Reply bit follows edge count; before the first phase-1 setup edge it is junk
  always @(n, qn, cpha_i, lsb_i) begin
    b = cpha_i ? (n - 1) / 2 : n / 2;
    if (tx_q.size() == 0) miso_o = 1'b1;
    else if (cpha_i && n == 0) miso_o = ~tx_q[0][lsb_i ? 0 : 7];
    else miso_o = tx_q[0][lsb_i ? b : 7 - b];
  end

  // Count edges away from and back to idle; sample opposite the setup edge
  always @(sck_i) begin
    if (sck_i === ~cpol_i || n[0]) begin
      n = n + 1;
      if (n[0] != cpha_i) sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
      if (n == 16) begin
        got_q.push_back(sh);
        void'(tx_q.pop_front());
        n = 0;
        qn++;
      end
    end
  end
endmodule

/* ums_sync.sv */
`timescale 1ns/10ps
module ums_sync
  import ums_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_ff;

  // Two-stage synchroniser; first stage read only by the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      q_o     <= 1'b0;
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule
